// ===== rtl/sbcc_defs.vh
// constants for the status byte and common command block
`ifndef SBCC_DEFS_VH
`define SBCC_DEFS_VH

// ----------------------------------------------------------------
// command codes on cmd_code
// ----------------------------------------------------------------
`define SBCC_CMD_RST      4'h0
`define SBCC_CMD_MSK_SET  4'h1
`define SBCC_CMD_MSK_QRY  4'h2
`define SBCC_CMD_SBY_QRY  4'h3
`define SBCC_CMD_TRG      4'h4
`define SBCC_CMD_TST_QRY  4'h5
`define SBCC_CMD_WAI      4'h6
`define SBCC_CMD_ESE_SET  4'h7
`define SBCC_CMD_ESR_QRY  4'h8
`define SBCC_CMD_LIM_CLR  4'h9
`define SBCC_CMD_CFG_SET  4'hA
`define SBCC_CMD_CFG_QRY  4'hB

// ----------------------------------------------------------------
// status byte bit positions
// ----------------------------------------------------------------
`define SBCC_SBY_EAV      2
`define SBCC_SBY_QSB      3
`define SBCC_SBY_MAV      4
`define SBCC_SBY_ESB      5
`define SBCC_SBY_MSS      6
`define SBCC_SBY_OSB      7

// ----------------------------------------------------------------
// event status bit positions
// ----------------------------------------------------------------
`define SBCC_ESR_OPC      0
`define SBCC_ESR_DDE      3
`define SBCC_ESR_CME      5
`define SBCC_ESR_USED     8'h29

// ----------------------------------------------------------------
// config flag positions in cmd_arg for the config command
// ----------------------------------------------------------------
`define SBCC_CFG_TOFS     0
`define SBCC_CFG_FOVW     1
`define SBCC_CFG_CAL      2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SBCC_MSK_RST      8'h00
`define SBCC_ESE_RST      8'h00
`define SBCC_ESR_RST      8'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SBCC_CLK_NS       10
`define SBCC_TST_TIME_NS  2000
`define SBCC_TST_CYCLES   (`SBCC_TST_TIME_NS / `SBCC_CLK_NS)

`endif

// ===== rtl/sbcc_selftest.v
// self-test sequencer: runs a fixed time, then returns a result code
`timescale 1ns/1ps
`default_nettype none
`include "sbcc_defs.vh"

module sbcc_selftest
#(
   parameter CNT_W = 12
)
(
   input  wire        sys_clk,    // system clock
   input  wire        rst_n,      // sync reset, active low
   input  wire        start,      // one-cycle start pulse
   input  wire [15:0] fault_code, // signed result, 0 = pass
   output reg         busy,       // test running
   output reg         done,       // one-cycle completion pulse
   output reg  [15:0] result      // captured result code
);

   localparam [CNT_W-1:0] LAST = `SBCC_TST_CYCLES - 1;

   reg [CNT_W-1:0] cnt_q;

   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         busy   <= 1'b0;
         done   <= 1'b0;
         result <= 16'h0000;
         cnt_q  <= {CNT_W{1'b0}};
      end
      else
      begin
         done <= 1'b0;
         if (start && !busy)
         begin
            busy  <= 1'b1;
            cnt_q <= {CNT_W{1'b0}};
         end
         else if (busy)
         begin
            if (cnt_q == LAST)
            begin
               // fault code sampled only at the end of the run
               busy   <= 1'b0;
               done   <= 1'b1;
               result <= fault_code;
            end
            else
               cnt_q <= cnt_q + 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// ===== rtl/sbcc_core.v
// status byte, service request mask and common command handling
`timescale 1ns/1ps
`default_nettype none
`include "sbcc_defs.vh"

module sbcc_core
#(
   parameter NUM_CHAN = 2
)
(
   input  wire                sys_clk,       // system clock, 100 MHz
   input  wire                rst_n,         // sync reset, active low
   input  wire                cmd_valid,     // decoded command present
   input  wire [3:0]          cmd_code,      // command code
   input  wire [7:0]          cmd_arg,       // numeric argument
   input  wire [1:0]          cmd_suffix,    // channel suffix, 0 = none
   output wire                cmd_ready,     // command taken this cycle
   output reg                 rsp_valid,     // answer waiting
   output reg  [15:0]         rsp_data,      // answer value
   input  wire                rsp_ack,       // controller took answer
   input  wire                err_nonempty,  // error queue holds entries
   input  wire [15:0]         ques_cond,     // questionable conditions
   input  wire [15:0]         ques_enable,   // questionable enables
   input  wire [15:0]         oper_cond,     // operation conditions
   input  wire [15:0]         oper_enable,   // operation enables
   input  wire                evt_opc,       // operation complete event
   input  wire                evt_dde,       // device error event
   input  wire [15:0]         tst_fault,     // self-test result code
   input  wire [NUM_CHAN-1:0] lim_low_hit,   // power below lower limit
   input  wire [NUM_CHAN-1:0] lim_high_hit,  // power above upper limit
   output reg  [7:0]          sbyte,         // status byte for polling
   output reg                 srq,           // service request, high
   output reg  [7:0]          srmask,        // service request mask
   output reg  [7:0]          ese,           // event status enables
   output reg  [7:0]          esr,           // event status latches
   output reg                 meas_stop,     // pulse: stop measuring
   output reg                 load_defaults, // pulse: default settings
   output reg                 err_clear,     // pulse: flush error queues
   output reg                 trig,          // pulse: group trigger
   output reg                 temp_ofs_en,   // sensor temp offset flag
   output reg                 file_ovw_en,   // file overwrite allowed
   output reg                 cal_en,        // calibrator output on
   output wire [NUM_CHAN-1:0] lim_low_lat,   // latched low alarms
   output wire [NUM_CHAN-1:0] lim_high_lat,  // latched high alarms
   output wire                tst_busy       // self-test running
);

   // -------------------------------------------------------------
   // command sequencer states
   // -------------------------------------------------------------
   localparam [1:0] ST_IDLE = 2'd0;
   localparam [1:0] ST_TEST = 2'd1;
   localparam [1:0] ST_RESP = 2'd2;
   reg  [1:0]          state_q;
   reg  [1:0]          state_d;
   reg  [NUM_CHAN-1:0] lim_clr;
   reg                 cme_set;
   reg                 esr_rd;
   reg                 tst_start;
   reg                 rsp_load;
   reg  [15:0]         rsp_val;
   reg  [7:0]          sbyte_d;
   wire                tst_done;
   wire [15:0]         tst_result;
   wire                take;
   wire                sfx_ok;
   wire [7:0]          esr_new;
   // one command at a time: nothing taken while test or answer pends
   assign cmd_ready = (state_q == ST_IDLE);
   assign take      = cmd_valid && cmd_ready;
   // suffix 3 never valid; suffix 2 only with a second channel
   assign sfx_ok = (cmd_suffix != 2'd3) &&
                   ((cmd_suffix != 2'd2) || (NUM_CHAN > 1));

   // -------------------------------------------------------------
   // decode
   // -------------------------------------------------------------
   always @*
   begin
      state_d   = state_q;
      lim_clr   = {NUM_CHAN{1'b0}};
      cme_set   = 1'b0;
      esr_rd    = 1'b0;
      tst_start = 1'b0;
      rsp_load  = 1'b0;
      rsp_val   = 16'h0000;
      case (state_q)
         ST_IDLE:
         begin
            if (take)
            begin
               case (cmd_code)
                  `SBCC_CMD_MSK_QRY:
                  begin
                     rsp_load = 1'b1;
                     rsp_val  = {8'h00, srmask};
                     state_d  = ST_RESP;
                  end
                  `SBCC_CMD_SBY_QRY:
                  begin
                     rsp_load = 1'b1;
                     rsp_val  = {8'h00, sbyte};
                     state_d  = ST_RESP;
                  end
                  `SBCC_CMD_ESR_QRY:
                  begin
                     rsp_load = 1'b1;
                     rsp_val  = {8'h00, esr};
                     esr_rd   = 1'b1;
                     state_d  = ST_RESP;
                  end
                  `SBCC_CMD_CFG_QRY:
                  begin
                     rsp_load = 1'b1;
                     rsp_val  = {13'h0000, cal_en, file_ovw_en, temp_ofs_en};
                     state_d  = ST_RESP;
                  end
                  `SBCC_CMD_TST_QRY:
                  begin
                     tst_start = 1'b1;
                     state_d   = ST_TEST;
                  end
                  `SBCC_CMD_LIM_CLR:
                  begin
                     if (!sfx_ok)
                        cme_set = 1'b1;
                     else if (cmd_suffix == 2'd2)
                        lim_clr[NUM_CHAN-1] = 1'b1;
                     else
                        lim_clr[0] = 1'b1;
                  end
                  `SBCC_CMD_RST,
                  `SBCC_CMD_MSK_SET,
                  `SBCC_CMD_ESE_SET,
                  `SBCC_CMD_CFG_SET,
                  `SBCC_CMD_TRG,
                  `SBCC_CMD_WAI:
                     cme_set = 1'b0;
                  default:
                     cme_set = 1'b1;
               endcase
            end
         end
         ST_TEST:
         begin
            if (tst_done)
            begin
               rsp_load = 1'b1;
               rsp_val  = tst_result;
               state_d  = ST_RESP;
            end
         end
         ST_RESP:
         begin
            if (rsp_ack)
               state_d = ST_IDLE;
         end
         default:
            state_d = ST_IDLE;
      endcase
   end

   // -------------------------------------------------------------
   // control registers and command side effects
   // -------------------------------------------------------------
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state_q       <= ST_IDLE;
         rsp_valid     <= 1'b0;
         rsp_data      <= 16'h0000;
         srmask        <= `SBCC_MSK_RST;
         ese           <= `SBCC_ESE_RST;
         meas_stop     <= 1'b0;
         load_defaults <= 1'b0;
         err_clear     <= 1'b0;
         trig          <= 1'b0;
         temp_ofs_en   <= 1'b0;
         file_ovw_en   <= 1'b0;
         cal_en        <= 1'b0;
      end
      else
      begin
         state_q       <= state_d;
         meas_stop     <= 1'b0;
         load_defaults <= 1'b0;
         err_clear     <= 1'b0;
         trig          <= 1'b0;
         if (rsp_load)
         begin
            rsp_valid <= 1'b1;
            rsp_data  <= rsp_val;
         end
         else if (rsp_ack)
            rsp_valid <= 1'b0;
         if (take)
         begin
            case (cmd_code)
               `SBCC_CMD_RST:
               begin
                  // masks and interface settings are left alone
                  meas_stop     <= 1'b1;
                  load_defaults <= 1'b1;
                  err_clear     <= 1'b1;
                  temp_ofs_en   <= 1'b0;
                  file_ovw_en   <= 1'b0;
                  cal_en        <= 1'b0;
               end
               `SBCC_CMD_MSK_SET:
                  srmask <= cmd_arg;
               `SBCC_CMD_ESE_SET:
                  ese <= cmd_arg;
               `SBCC_CMD_CFG_SET:
               begin
                  temp_ofs_en <= cmd_arg[`SBCC_CFG_TOFS];
                  file_ovw_en <= cmd_arg[`SBCC_CFG_FOVW];
                  cal_en      <= cmd_arg[`SBCC_CFG_CAL];
               end
               `SBCC_CMD_TRG:
                  trig <= 1'b1;
               default:
                  trig <= 1'b0;
            endcase
         end
      end
   end

   // -------------------------------------------------------------
   // event status: new events win over the read-clear
   // -------------------------------------------------------------
   assign esr_new = ({7'h00, evt_opc} << `SBCC_ESR_OPC) |
                    ({7'h00, evt_dde} << `SBCC_ESR_DDE) |
                    ({7'h00, cme_set} << `SBCC_ESR_CME);

   always @(posedge sys_clk)
   begin
      if (!rst_n)
         esr <= `SBCC_ESR_RST;
      else
         esr <= ((esr_rd ? 8'h00 : esr) | esr_new) &
                `SBCC_ESR_USED;
   end

   // -------------------------------------------------------------
   // status byte and service request
   // -------------------------------------------------------------
   always @*
   begin
      sbyte_d                = 8'h00;
      sbyte_d[`SBCC_SBY_EAV] = err_nonempty;
      sbyte_d[`SBCC_SBY_QSB] = |(ques_cond & ques_enable);
      sbyte_d[`SBCC_SBY_MAV] = rsp_valid;
      sbyte_d[`SBCC_SBY_ESB] = |(esr & ese);
      sbyte_d[`SBCC_SBY_OSB] = |(oper_cond & oper_enable);
      sbyte_d[`SBCC_SBY_MSS] = |sbyte_d;
   end
   always @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         sbyte <= 8'h00;
         srq   <= 1'b0;
      end
      else
      begin
         sbyte <= sbyte_d;
         // master summary is not itself a request source
         srq   <= |(sbyte_d & srmask & 8'hBF);
      end
   end

   // -------------------------------------------------------------
   // per-channel latched limit alarms
   // -------------------------------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHAN; ch = ch + 1)
      begin : g_lim
         reg lo_q;
         reg hi_q;
         // a crossing in the clear cycle survives the clear
         always @(posedge sys_clk)
         begin
            if (!rst_n)
            begin
               lo_q <= 1'b0;
               hi_q <= 1'b0;
            end
            else
            begin
               lo_q <= (lo_q & ~lim_clr[ch]) | lim_low_hit[ch];
               hi_q <= (hi_q & ~lim_clr[ch]) | lim_high_hit[ch];
            end
         end
         assign lim_low_lat[ch]  = lo_q;
         assign lim_high_lat[ch] = hi_q;
      end
   endgenerate

   // -------------------------------------------------------------
   // self-test sequencer
   // -------------------------------------------------------------
   sbcc_selftest u_tst
   (
      .sys_clk    (sys_clk),
      .rst_n      (rst_n),
      .start      (tst_start),
      .fault_code (tst_fault),
      .busy       (tst_busy),
      .done       (tst_done),
      .result     (tst_result)
   );

endmodule
`default_nettype wire

// ===== verification/sbcc_core_checker.sv
// assertion checker for the status byte and common command block
`timescale 1ns/1ps
`default_nettype none
`include "sbcc_defs.vh"
module sbcc_core_checker
#(
   parameter NUM_CHAN = 2
)
(
   input wire logic                sys_clk,      // clock
   input wire logic                rst_n,        // reset
   input wire logic                cmd_valid,    // command present
   input wire logic [3:0]          cmd_code,     // command code
   input wire logic [7:0]          cmd_arg,      // argument
   input wire logic                cmd_ready,    // command taken
   input wire logic                rsp_valid,    // answer waiting
   input wire logic                err_nonempty, // error queue
   input wire logic [7:0]          esr,          // event latches
   input wire logic [7:0]          ese,          // event enables
   input wire logic [7:0]          sbyte,        // status byte
   input wire logic                srq,          // service request
   input wire logic [7:0]          srmask,       // request mask
   input wire logic                meas_stop,    // stop pulse
   input wire logic                cal_en,       // calibrator
   input wire logic                trig,         // trigger pulse
   input wire logic [NUM_CHAN-1:0] lim_low_hit,  // low crossing
   input wire logic [NUM_CHAN-1:0] lim_low_lat   // low alarms
);
   wire take = cmd_valid & cmd_ready;
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // properties
   // ----------------------------------------
   // past(rst_n) guards: the reset edge itself forces the status byte low
   a_unused_low_bits: assert property (sbyte[1:0] == 2'b00)
      else $error("unused status bits set");
   a_master_summary: assert property (
      sbyte[6] == |{sbyte[7], sbyte[5:0]}) else $error("summary bit wrong");
   a_queue_bit: assert property (
      $past(rst_n) |-> sbyte[2] == $past(err_nonempty))
      else $error("queue bit wrong");
   a_event_summary: assert property (
      $past(rst_n) |-> sbyte[5] == |$past(esr & ese))
      else $error("event summary wrong");
   a_srq_gate: assert property (
      srq == |(sbyte & $past(srmask) & 8'hBF)) else $error("srq wrong");
   a_mask_write: assert property (
      $past(rst_n && take && cmd_code == `SBCC_CMD_MSK_SET)
      |-> srmask == $past(cmd_arg)) else $error("mask not written");
   a_reset_cmd: assert property (
      $past(rst_n && take && cmd_code == `SBCC_CMD_RST)
      |-> meas_stop && !cal_en && $stable(srmask))
      else $error("reset command effect wrong");
   a_trig_pulse: assert property (
      $past(rst_n) |-> trig == $past(take && cmd_code == `SBCC_CMD_TRG))
      else $error("trigger pulse wrong");
   a_test_answer: assert property (
      take && cmd_code == `SBCC_CMD_TST_QRY
      |-> ##1 (!cmd_ready)[*8] ##[192:196] rsp_valid)
      else $error("self-test answer late or overlapped");
   a_alarm_latch: assert property (
      $past(rst_n) |-> (lim_low_lat & $past(lim_low_hit))
      == $past(lim_low_hit)) else $error("alarm not latched");
   c_srq: cover property (srq);
   c_trig: cover property (trig);
   c_clear: cover property ($fell(|lim_low_lat));
endmodule
bind sbcc_core sbcc_core_checker #(.NUM_CHAN(NUM_CHAN)) chk (
   .sys_clk, .rst_n, .cmd_valid, .cmd_code, .cmd_arg, .cmd_ready,
   .rsp_valid, .err_nonempty, .esr, .ese, .sbyte, .srq, .srmask,
   .meas_stop, .cal_en, .trig, .lim_low_hit, .lim_low_lat
);
`default_nettype wire

// ===== verification/sbcc_host.sv
// bus controller model: issues commands and takes answers
`timescale 1ns/1ps
`default_nettype none
module sbcc_host
(
   input  wire logic        sys_clk,    // clock
   output logic             cmd_valid,  // command present
   output logic [3:0]       cmd_code,   // command code
   output logic [7:0]       cmd_arg,    // argument
   output logic [1:0]       cmd_suffix, // channel suffix
   input  wire logic        cmd_ready,  // command taken
   input  wire logic        rsp_valid,  // answer waiting
   input  wire logic [15:0] rsp_data,   // answer value
   output logic             rsp_ack,    // answer taken
   output logic             hang        // a wait ran out
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_code = 4'h6;
      cmd_arg = 8'h00;
      cmd_suffix = 2'h0;
      rsp_ack = 1'b0;
      hang = 1'b0;
   end
   // ----------------------------------------
   // transfers
   // ----------------------------------------
   task automatic send(input logic [3:0] c, input logic [7:0] a,
                       input logic [1:0] s);
      int n;
      n = 0;
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_arg = a;
      cmd_suffix = s;
      @(posedge sys_clk);
      while (!cmd_ready && n < 300)
      begin
         n++;
         @(posedge sys_clk);
      end
      if (!cmd_ready)
         hang = 1'b1;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
      // stale lines flip so a leftover value never passes as fresh
      cmd_code = ~c;
      cmd_arg = ~a;
      cmd_suffix = ~s;
   endtask
   // dly slows the controller to show the answer standing
   task automatic get_rsp(input int dly, output logic [15:0] d);
      int n;
      n = 0;
      while (!rsp_valid && n < 300)
      begin
         n++;
         @(negedge sys_clk);
      end
      if (!rsp_valid)
         hang = 1'b1;
      repeat (dly) @(negedge sys_clk);
      rsp_ack = 1'b1;
      @(posedge sys_clk);
      d = rsp_data;
      @(negedge sys_clk);
      rsp_ack = 1'b0;
   endtask
endmodule
`default_nettype wire

// ===== verification/sbcc_core_tb.sv
// self-checking bench for the status byte and common command block
`timescale 1ns/1ps
`default_nettype none
`include "sbcc_defs.vh"
module sbcc_core_tb;
   logic        sys_clk, rst_n, err_nonempty, evt_opc, evt_dde;
   logic [15:0] ques_cond, ques_enable, oper_cond, oper_enable, tst_fault;
   logic [1:0]  lim_low_hit, lim_high_hit;
   wire         cmd_valid, cmd_ready, rsp_valid, rsp_ack, hang, srq;
   wire         meas_stop, load_defaults, err_clear, trig, tst_busy;
   wire         temp_ofs_en, file_ovw_en, cal_en;
   wire [3:0]   cmd_code;
   wire [7:0]   cmd_arg, sbyte, srmask, ese, esr;
   wire [1:0]   cmd_suffix, lim_low_lat, lim_high_lat;
   wire [15:0]  rsp_data;
   int          error_cnt = 0;
   int          cmp_count = 0;
   logic [15:0] d;
   sbcc_core #(.NUM_CHAN(2)) uut (.sys_clk, .rst_n, .cmd_valid, .cmd_code,
      .cmd_arg, .cmd_suffix, .cmd_ready, .rsp_valid, .rsp_data, .rsp_ack,
      .err_nonempty, .ques_cond, .ques_enable, .oper_cond, .oper_enable,
      .evt_opc, .evt_dde, .tst_fault, .lim_low_hit, .lim_high_hit, .sbyte,
      .srq, .srmask, .ese, .esr, .meas_stop, .load_defaults, .err_clear,
      .trig, .temp_ofs_en, .file_ovw_en, .cal_en, .lim_low_lat,
      .lim_high_lat, .tst_busy);
   sbcc_host host (.sys_clk, .cmd_valid, .cmd_code, .cmd_arg, .cmd_suffix,
      .cmd_ready, .rsp_valid, .rsp_data, .rsp_ack, .hang);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input string nm, input logic [15:0] seen,
                      input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic esr_read(input logic [7:0] e);
      host.send(`SBCC_CMD_ESR_QRY, 8'h00, 2'h0);
      host.get_rsp(0, d);
      chk("esr read", d, {8'h00, e});
      cyc(1);
      chk("esr cleared", esr, 8'h00);
   endtask
   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_mask;
      chk("reset state", {srmask, sbyte}, 16'h0000);
      host.send(`SBCC_CMD_MSK_SET, 8'hFF, 2'h0);
      host.send(`SBCC_CMD_MSK_QRY, 8'h00, 2'h0);
      host.get_rsp(0, d);
      chk("mask read", d, 16'h00FF);
      err_nonempty = 1'b1;
      cyc(3);
      chk("queue bit", {srq, sbyte}, 9'h144);
      host.send(`SBCC_CMD_MSK_SET, 8'hFB, 2'h0);
      cyc(2);
      chk("masked srq", srq, 1'b0);
      host.send(`SBCC_CMD_MSK_SET, 8'h00, 2'h0);
      err_nonempty = 1'b0;
   endtask
   task automatic t_summary;
      ques_cond = 16'h0100;
      oper_cond = 16'h8000;
      cyc(2);
      chk("disabled", sbyte, 8'h00);
      ques_enable = 16'h0100;
      cyc(2);
      chk("ques sum", sbyte, 8'h48);
      ques_enable = 16'h0000;
      oper_enable = 16'hFFFF;
      cyc(2);
      chk("oper sum", sbyte, 8'hC0);
      {oper_cond, oper_enable, ques_cond} = 48'h0;
   endtask
   task automatic t_event;
      host.send(`SBCC_CMD_ESE_SET, 8'h08, 2'h0);
      evt_opc = 1'b1;
      evt_dde = 1'b1;
      cyc(1);
      evt_opc = 1'b0;
      evt_dde = 1'b0;
      cyc(2);
      chk("event sum", {esr, sbyte}, 16'h0960);
      esr_read(8'h09);
   endtask
   task automatic t_stb;
      err_nonempty = 1'b1;
      cyc(2);
      host.send(`SBCC_CMD_SBY_QRY, 8'h00, 2'h0);
      cyc(1);
      chk("answer bit", sbyte, 8'h54);
      host.get_rsp(2, d);
      chk("stb read", d, 16'h0044);
      err_nonempty = 1'b0;
   endtask
   task automatic t_rst;
      host.send(`SBCC_CMD_MSK_SET, 8'h55, 2'h0);
      host.send(`SBCC_CMD_CFG_SET, 8'h07, 2'h0);
      chk("cfg on", {cal_en, file_ovw_en, temp_ofs_en}, 3'h7);
      host.send(`SBCC_CMD_CFG_QRY, 8'h00, 2'h0);
      host.get_rsp(0, d);
      chk("cfg read", d, 16'h0007);
      host.send(`SBCC_CMD_RST, 8'h00, 2'h0);
      chk("pulses", {meas_stop, load_defaults, err_clear}, 3'h7);
      chk("flags", {cal_en, file_ovw_en, temp_ofs_en}, 3'h0);
      chk("masks kept", {srmask, ese}, 16'h5508);
      cyc(1);
      chk("pulse end", meas_stop, 1'b0);
      host.send(`SBCC_CMD_MSK_SET, 8'h00, 2'h0);
   endtask
   task automatic t_trig;
      host.send(`SBCC_CMD_TRG, 8'h00, 2'h0);
      chk("trig", trig, 1'b1);
      cyc(1);
      chk("trig end", trig, 1'b0);
      host.send(`SBCC_CMD_WAI, 8'h00, 2'h0);
      cyc(1);
      chk("wait", {trig, esr, cmd_ready}, 10'h001);
      host.send(4'hC, 8'h00, 2'h0);
      cyc(1);
      chk("bad code", esr, 8'h20);
      esr_read(8'h20);
   endtask
   task automatic t_test;
      logic [15:0] f [2];
      f[0] = 16'h0000;
      f[1] = 16'hFFF3;
      for (int i = 0; i < 2; i++)
      begin
         tst_fault = f[i];
         host.send(`SBCC_CMD_TST_QRY, 8'h00, 2'h0);
         chk("busy", {tst_busy, cmd_ready}, 2'h2);
         host.get_rsp(0, d);
         chk("test code", d, f[i]);
      end
   endtask
   task automatic t_limits;
      lim_low_hit = 2'h1;
      lim_high_hit = 2'h2;
      cyc(1);
      lim_low_hit = 2'h0;
      lim_high_hit = 2'h0;
      cyc(6);
      chk("latched", {lim_low_lat, lim_high_lat}, 4'h6);
      host.send(`SBCC_CMD_LIM_CLR, 8'h00, 2'h2);
      cyc(1);
      chk("clear ch2", {lim_low_lat, lim_high_lat}, 4'h4);
      host.send(`SBCC_CMD_LIM_CLR, 8'h00, 2'h3);
      cyc(1);
      chk("bad suffix", {lim_low_lat, esr}, 10'h120);
      host.send(`SBCC_CMD_LIM_CLR, 8'h00, 2'h1);
      cyc(1);
      chk("clear ch1", lim_low_lat, 2'h0);
      esr_read(8'h20);
   endtask
   // ----------------------------------------
   // run
   // ----------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   initial
   begin
      rst_n = 1'b0;
      {err_nonempty, evt_opc, evt_dde, lim_low_hit, lim_high_hit} = 7'h00;
      {ques_cond, ques_enable, oper_cond, oper_enable} = 64'h0;
      tst_fault = 16'h0000;
      repeat (10) @(negedge sys_clk);
      rst_n = 1'b1;
      t_mask;
      t_summary;
      t_event;
      t_stb;
      t_rst;
      t_trig;
      t_test;
      t_limits;
      chk("host waits", hang, 1'b0);
      complete_run;
   end
   // whole run is near 490 cycles; this limit is twenty times that
   initial
   begin
      #100000;
      error_cnt++;
      complete_run;
   end
endmodule
`default_nettype wire
